// ### include/pmcal_pkg.sv
// pmcal_pkg: constants and types shared by the calibration device end and the host end.
// assumes one clock (aclk) and a synchronous active-low reset (aresetn) on both ends.
package pmcal_pkg;
	localparam int          GAIN_W         = 16;
	localparam int          DATA_W         = 32;
	localparam int          RANGE_W        = 5;
	localparam logic [16:0] GAIN_MIN       = 17'h061a8;
	localparam logic [16:0] GAIN_MAX       = 17'h0ffff;
	localparam logic [15:0] GAIN_RST       = 16'h8000;
	localparam logic [4:0]  RANGE_RST      = 5'h0c;
	localparam int          PHASE_STEPS_DEG = 40;
	localparam int          PHASE_MAX_X10  = 32;
	localparam logic [7:0]  PHASE_LIM      = 8'h80;
	localparam int          FREQ_MIN_HZ    = 45;
	localparam int          FREQ_MAX_HZ    = 65;
	localparam int          DIV_CYCLES     = 48;
	// host register offsets, one aligned word each
	localparam logic [7:0]  A_CTRL         = 8'h00;
	localparam logic [7:0]  A_STATUS       = 8'h04;
	localparam logic [7:0]  A_EXP_I        = 8'h08;
	localparam logic [7:0]  A_EXP_V        = 8'h0c;
	localparam logic [7:0]  A_EXP_P        = 8'h10;
	localparam logic [7:0]  A_PHASE        = 8'h14;
	localparam logic [7:0]  A_RANGE        = 8'h18;
	localparam logic [7:0]  A_GAINS_IV     = 8'h1c;
	localparam logic [7:0]  A_GAIN_P       = 8'h20;
	localparam logic [7:0]  A_FREQ         = 8'h24;
	localparam logic [7:0]  A_OFFS         = 8'h28;
	// command codes on the link
	typedef enum logic [1:0] {PMCAL_CMD_NONE, PMCAL_CMD_GAIN, PMCAL_CMD_PHASE,
		PMCAL_CMD_SAVE} pmcal_cmd_e;
endpackage

// ### include/pmcal_if.sv
// pmcal_if: command link between host controller and calibration engine.
// assumes both ends share aclk; a command is one cycle pulse, answer one pulse.
`timescale 1ns/1ps
interface pmcal_if;
	import pmcal_pkg::*;
	logic             cmd_valid;
	pmcal_cmd_e       cmd;
	logic [31:0]      exp_i;
	logic [31:0]      exp_v;
	logic [31:0]      exp_p;
	logic [7:0]       phase_delta;
	logic [4:0]       range_sel;
	logic             dc_mode;
	logic [15:0]      ac_off_i;
	logic [15:0]      ac_off_p;
	logic [15:0]      ac_off_q;
	logic [15:0]      dc_off_i;
	logic             resp_valid;
	logic             resp_ack;
	logic             busy;
	logic [15:0]      gain_i;
	logic [15:0]      gain_v;
	logic [15:0]      gain_p;
	logic [15:0]      phase_comp;
	logic [15:0]      line_freq;
	modport host (output cmd_valid, cmd, exp_i, exp_v, exp_p, phase_delta, range_sel,
		dc_mode, ac_off_i, ac_off_p, ac_off_q, dc_off_i,
		input resp_valid, resp_ack, busy, gain_i, gain_v, gain_p, phase_comp, line_freq);
	modport dev (input cmd_valid, cmd, exp_i, exp_v, exp_p, phase_delta, range_sel,
		dc_mode, ac_off_i, ac_off_p, ac_off_q, dc_off_i,
		output resp_valid, resp_ack, busy, gain_i, gain_v, gain_p, phase_comp, line_freq);
endinterface

// ### verilog/pmcal_dev.sv
// pmcal_dev: calibration engine: gain autocal, range shift, phase, offsets, frequency.
// assumes converter samples and measured outputs arrive synchronous to aclk.
//
// Our own choices: the register offsets and the AXI4-Lite slave port.
`timescale 1ns/1ps
module pmcal_dev
	import pmcal_pkg::*;
#(
	parameter int SAMPLE_W = 24
) (
	input  wire logic                 aclk,
	input  wire logic                 aresetn,
	pmcal_if.dev                      lnk,
	input  wire logic [SAMPLE_W-1:0]  adc_i,
	input  wire logic [SAMPLE_W-1:0]  adc_v,
	input  wire logic [SAMPLE_W-1:0]  hpf_i,
	input  wire logic [SAMPLE_W-1:0]  hpf_v,
	input  wire logic [31:0]          raw_i,
	input  wire logic [31:0]          raw_v,
	input  wire logic [31:0]          raw_p,
	input  wire logic [31:0]          raw_q,
	input  wire logic [15:0]          freq_meas,
	output logic      [SAMPLE_W-1:0]  chan_i,
	output logic      [SAMPLE_W-1:0]  chan_v,
	output logic      [31:0]          out_i,
	output logic      [31:0]          out_v,
	output logic      [31:0]          out_p,
	output logic      [31:0]          out_q
);
	typedef enum logic [1:0] {PMCAL_IDLE, PMCAL_DIV, PMCAL_CHECK} pmcal_state_e;
	typedef struct packed {
		pmcal_state_e        st;
		logic [5:0]          cnt;
		logic [1:0]          ch;
		logic [47:0]         num;
		logic [31:0]         den;
		logic [47:0]         quo;
		logic [16:0]         new_i;
		logic [16:0]         new_v;
		logic [16:0]         new_p;
		logic [15:0]         gain_i;
		logic [15:0]         gain_v;
		logic [15:0]         gain_p;
		logic [15:0]         phase;
		logic [15:0]         freq;
		logic                rv;
		logic                ack;
		logic [SAMPLE_W-1:0] ci;
		logic [SAMPLE_W-1:0] cv;
		logic [31:0]         oi;
		logic [31:0]         ov;
		logic [31:0]         op;
		logic [31:0]         oq;
	} pmcal_dev_s;

	pmcal_dev_s s_reg, s_next;

	// saturating 17-bit result of the restoring division
	function automatic logic [16:0] pmcal_sat(input logic [47:0] q);
		pmcal_sat = (|q[47:17]) ? 17'h1ffff : q[16:0];
	endfunction

	function automatic logic pmcal_ok(input logic [16:0] g);
		pmcal_ok = (g >= GAIN_MIN) && (g <= GAIN_MAX);
	endfunction

	// gain scaled output, shifted right by range
	function automatic logic [31:0] pmcal_scale(input logic [31:0] x, input logic [15:0] g,
		input logic [4:0] r);
		logic [47:0] prod;
		prod = 48'(x) * 48'(g);
		pmcal_scale = 32'(prod >> r);
	endfunction

	logic [31:0] meas;
	logic [31:0] expv;
	logic [15:0] gold;
	logic [48:0] trial;
	logic [7:0]  ph_sum;
	logic        ph_ovf;
	logic [1:0]  ch_sel;

	always_comb begin
		// channel whose division gets loaded: 0 from idle, else the following one
		if (s_reg.st == PMCAL_IDLE)
			ch_sel = 2'd0;
		else if (s_reg.cnt == 6'(DIV_CYCLES - 1))
			ch_sel = s_reg.ch + 2'd1;
		else
			ch_sel = s_reg.ch;
		case (ch_sel)
			2'd0: begin
				meas = s_reg.oi;
				expv = lnk.exp_i;
				gold = s_reg.gain_i;
			end
			2'd1: begin
				meas = s_reg.ov;
				expv = lnk.exp_v;
				gold = s_reg.gain_v;
			end
			default: begin
				meas = s_reg.op;
				expv = lnk.exp_p;
				gold = s_reg.gain_p;
			end
		endcase
	end

	always_comb begin
		s_next = s_reg;
		s_next.rv = 1'b0;
		trial = 49'h0;
		ph_sum = 8'(s_reg.phase[7:0] + lnk.phase_delta);
		ph_ovf = (s_reg.phase[7] == lnk.phase_delta[7]) && (ph_sum[7] != s_reg.phase[7]);
		// input stage: DC offset right at converter, high-pass bypassed in DC mode
		// offset lands on raw converter samples, ahead of any other stage
		s_next.ci = lnk.dc_mode ? adc_i + SAMPLE_W'(lnk.dc_off_i) : hpf_i;
		s_next.cv = lnk.dc_mode ? adc_v : hpf_v;
		s_next.oi = pmcal_scale(raw_i, s_reg.gain_i, lnk.range_sel) + 32'(lnk.ac_off_i);
		s_next.ov = pmcal_scale(raw_v, s_reg.gain_v, lnk.range_sel);
		s_next.op = pmcal_scale(raw_p, s_reg.gain_p, lnk.range_sel) + 32'(lnk.ac_off_p);
		s_next.oq = pmcal_scale(raw_q, s_reg.gain_p, lnk.range_sel) + 32'(lnk.ac_off_q);
		s_next.freq = lnk.dc_mode ? 16'h0000 : freq_meas;
		case (s_reg.st)
			PMCAL_IDLE: begin
				s_next.ch = 2'd0;
				if (lnk.cmd_valid && lnk.cmd == PMCAL_CMD_GAIN) begin
					s_next.st = PMCAL_DIV;
					s_next.cnt = 6'd0;
					s_next.num = 48'(gold) * 48'(expv);
					s_next.den = meas;
					s_next.quo = 48'h0;
				end else if (lnk.cmd_valid && lnk.cmd == PMCAL_CMD_PHASE) begin
					s_next.rv = 1'b1;
					s_next.ack = ~ph_ovf;
					if (!ph_ovf)
						s_next.phase = {s_reg.phase[15:8], ph_sum};
				end else if (lnk.cmd_valid && lnk.cmd == PMCAL_CMD_SAVE) begin
					s_next.rv = 1'b1;
					s_next.ack = 1'b1;
				end
			end
			PMCAL_DIV: begin
				trial = {s_reg.quo, s_reg.num[47]} - {17'h0, s_reg.den};
				s_next.num = {s_reg.num[46:0], 1'b0};
				if (!trial[48])
					s_next.quo = trial[47:0];
				else
					s_next.quo = {s_reg.quo[46:0], s_reg.num[47]};
				s_next.num[0] = ~trial[48];
				s_next.cnt = s_reg.cnt + 6'd1;
				if (s_reg.cnt == 6'(DIV_CYCLES - 1)) begin
					case (s_reg.ch)
						2'd0: s_next.new_i = (s_reg.den == 32'h0) ? 17'h1ffff : pmcal_sat(s_next.num);
						2'd1: s_next.new_v = (s_reg.den == 32'h0) ? 17'h1ffff : pmcal_sat(s_next.num);
						default: s_next.new_p = (s_reg.den == 32'h0) ? 17'h1ffff : pmcal_sat(s_next.num);
					endcase
					if (s_reg.ch == 2'd2) begin
						s_next.st = PMCAL_CHECK;
					end else begin
						s_next.ch = s_reg.ch + 2'd1;
						s_next.cnt = 6'd0;
						s_next.quo = 48'h0;
						s_next.num = 48'(gold) * 48'(expv);
						s_next.den = meas;
					end
				end
			end
			PMCAL_CHECK: begin
				s_next.st = PMCAL_IDLE;
				s_next.rv = 1'b1;
				s_next.ack = pmcal_ok(s_reg.new_i) && pmcal_ok(s_reg.new_v) && pmcal_ok(s_reg.new_p);
				if (s_next.ack) begin
					s_next.gain_i = s_reg.new_i[15:0];
					s_next.gain_v = s_reg.new_v[15:0];
					s_next.gain_p = s_reg.new_p[15:0];
				end
			end
			default: s_next.st = PMCAL_IDLE;
		endcase
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			s_reg <= '0;
			s_reg.st <= PMCAL_IDLE;
			s_reg.gain_i <= GAIN_RST;
			s_reg.gain_v <= GAIN_RST;
			s_reg.gain_p <= GAIN_RST;
		end else begin
			s_reg <= s_next;
		end
	end

	assign lnk.resp_valid = s_reg.rv;
	assign lnk.resp_ack   = s_reg.ack;
	assign lnk.busy       = (s_reg.st != PMCAL_IDLE);
	assign lnk.gain_i     = s_reg.gain_i;
	assign lnk.gain_v     = s_reg.gain_v;
	assign lnk.gain_p     = s_reg.gain_p;
	assign lnk.phase_comp = s_reg.phase;
	assign lnk.line_freq  = s_reg.freq;
	assign chan_i         = s_reg.ci;
	assign chan_v         = s_reg.cv;
	assign out_i          = s_reg.oi;
	assign out_v          = s_reg.ov;
	assign out_p          = s_reg.op;
	assign out_q          = s_reg.oq;
endmodule // pmcal_dev

// ### verilog/pmcal_host.sv
// pmcal_host: AXI4-Lite slave register file that issues calibration commands.
// assumes the device end answers every command with one resp_valid pulse.
`timescale 1ns/1ps
module pmcal_host
	import pmcal_pkg::*;
(
	input  wire logic        aclk,
	input  wire logic        aresetn,
	pmcal_if.host            lnk,
	input  wire logic [7:0]  s_axi_awaddr,
	input  wire logic        s_axi_awvalid,
	output logic             s_axi_awready,
	input  wire logic [31:0] s_axi_wdata,
	input  wire logic [3:0]  s_axi_wstrb,
	input  wire logic        s_axi_wvalid,
	output logic             s_axi_wready,
	output logic [1:0]       s_axi_bresp,
	output logic             s_axi_bvalid,
	input  wire logic        s_axi_bready,
	input  wire logic [7:0]  s_axi_araddr,
	input  wire logic        s_axi_arvalid,
	output logic             s_axi_arready,
	output logic [31:0]      s_axi_rdata,
	output logic [1:0]       s_axi_rresp,
	output logic             s_axi_rvalid,
	input  wire logic        s_axi_rready
);
	typedef struct packed {
		logic        aw_ok;
		logic [7:0]  aw;
		logic        w_ok;
		logic [31:0] wd;
		logic [3:0]  ws;
		logic        bv;
		logic [1:0]  br;
		logic        rv;
		logic [31:0] rd;
		logic [1:0]  rr;
		logic        cv;
		pmcal_cmd_e  cmd;
		logic [31:0] ei;
		logic [31:0] ev;
		logic [31:0] ep;
		logic [7:0]  ph;
		logic [4:0]  rng;
		logic        dc;
		logic [15:0] oi;
		logic [15:0] op;
		logic [15:0] oq;
		logic [15:0] od;
		logic        pend;
		logic        done;
		logic        ack;
		logic        acked;
	} pmcal_host_s;

	pmcal_host_s s_reg, s_next;

	function automatic logic [31:0] pmcal_merge(input logic [31:0] o, input logic [31:0] d,
		input logic [3:0] b);
		for (int k = 0; k < 4; k++)
			pmcal_merge[k*8 +: 8] = b[k] ? d[k*8 +: 8] : o[k*8 +: 8];
	endfunction

	always_comb begin
		logic [31:0] m;
		m = 32'h0;
		s_next = s_reg;
		s_next.cv = 1'b0;
		if (s_axi_awvalid && s_axi_awready) begin
			s_next.aw_ok = 1'b1;
			s_next.aw = s_axi_awaddr;
		end
		if (s_axi_wvalid && s_axi_wready) begin
			s_next.w_ok = 1'b1;
			s_next.wd = s_axi_wdata;
			s_next.ws = s_axi_wstrb;
		end
		if (lnk.resp_valid) begin
			s_next.pend = 1'b0;
			s_next.done = 1'b1;
			s_next.ack = lnk.resp_ack;
			if (s_reg.cmd == PMCAL_CMD_GAIN)
				s_next.acked = lnk.resp_ack;
		end
		if (s_reg.aw_ok && s_reg.w_ok && !s_reg.bv) begin
			s_next.aw_ok = 1'b0;
			s_next.w_ok = 1'b0;
			s_next.bv = 1'b1;
			s_next.br = 2'b00;
			case (s_reg.aw)
				A_CTRL: begin
					s_next.dc = s_reg.ws[0] ? s_reg.wd[4] : s_reg.dc;
					if (s_reg.ws[0] && s_reg.wd[1:0] != 2'b00) begin
						if (s_reg.pend || lnk.busy ||
							(s_reg.wd[1:0] == 2'b11 && !s_reg.acked)) begin
							s_next.br = 2'b10;
						end else begin
							s_next.cv = 1'b1;
							s_next.cmd = pmcal_cmd_e'(s_reg.wd[1:0]);
							s_next.pend = 1'b1;
							s_next.done = 1'b0;
						end
					end
				end
				A_EXP_I: s_next.ei = pmcal_merge(s_reg.ei, s_reg.wd, s_reg.ws);
				A_EXP_V: s_next.ev = pmcal_merge(s_reg.ev, s_reg.wd, s_reg.ws);
				A_EXP_P: s_next.ep = pmcal_merge(s_reg.ep, s_reg.wd, s_reg.ws);
				A_PHASE: if (s_reg.ws[0]) s_next.ph = s_reg.wd[7:0];
				A_RANGE: if (s_reg.ws[0]) s_next.rng = s_reg.wd[4:0];
				A_OFFS: begin
					m = pmcal_merge({s_reg.op, s_reg.oi}, s_reg.wd, s_reg.ws);
					s_next.oi = m[15:0];
					s_next.op = m[31:16];
				end
				A_FREQ: begin
					m = pmcal_merge({s_reg.od, s_reg.oq}, s_reg.wd, s_reg.ws);
					s_next.oq = m[15:0];
					s_next.od = m[31:16];
				end
				default: s_next.br = 2'b10;
			endcase
		end
		if (s_axi_bvalid && s_axi_bready)
			s_next.bv = 1'b0;
		if (s_axi_arvalid && s_axi_arready) begin
			s_next.rv = 1'b1;
			s_next.rr = 2'b00;
			case (s_axi_araddr)
				A_CTRL:     s_next.rd = {27'h0, s_reg.dc, 2'b00, s_reg.cmd};
				A_STATUS:   s_next.rd = {28'h0, s_reg.acked, s_reg.ack, s_reg.done,
					s_reg.pend | lnk.busy};
				A_EXP_I:    s_next.rd = s_reg.ei;
				A_EXP_V:    s_next.rd = s_reg.ev;
				A_EXP_P:    s_next.rd = s_reg.ep;
				A_PHASE:    s_next.rd = {16'h0, lnk.phase_comp};
				A_RANGE:    s_next.rd = {27'h0, s_reg.rng};
				A_GAINS_IV: s_next.rd = {lnk.gain_v, lnk.gain_i};
				A_GAIN_P:   s_next.rd = {16'h0, lnk.gain_p};
				A_FREQ:     s_next.rd = {16'h0, lnk.line_freq};
				A_OFFS:     s_next.rd = {s_reg.op, s_reg.oi};
				default: begin
					s_next.rd = 32'h0;
					s_next.rr = 2'b10;
				end
			endcase
		end else if (s_axi_rvalid && s_axi_rready) begin
			s_next.rv = 1'b0;
		end
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			s_reg <= '0;
			s_reg.rng <= RANGE_RST;
		end else begin
			s_reg <= s_next;
		end
	end

	assign s_axi_awready   = ~s_reg.aw_ok;
	assign s_axi_wready    = ~s_reg.w_ok;
	assign s_axi_bvalid    = s_reg.bv;
	assign s_axi_bresp     = s_reg.br;
	assign s_axi_arready   = ~s_reg.rv;
	assign s_axi_rvalid    = s_reg.rv;
	assign s_axi_rdata     = s_reg.rd;
	assign s_axi_rresp     = s_reg.rr;
	assign lnk.cmd_valid   = s_reg.cv;
	assign lnk.cmd         = s_reg.cmd;
	assign lnk.exp_i       = s_reg.ei;
	assign lnk.exp_v       = s_reg.ev;
	assign lnk.exp_p       = s_reg.ep;
	assign lnk.phase_delta = s_reg.ph;
	assign lnk.range_sel   = s_reg.rng;
	assign lnk.dc_mode     = s_reg.dc;
	assign lnk.ac_off_i    = s_reg.oi;
	assign lnk.ac_off_p    = s_reg.op;
	assign lnk.ac_off_q    = s_reg.oq;
	assign lnk.dc_off_i    = s_reg.od;
endmodule // pmcal_host

// ### verif/pmcal_asserts.sv
// pmcal_asserts: checks on the link between host end and device end.
// assumes instantiation beside the pmcal_if instance, one clock domain.
`timescale 1ns/1ps
module pmcal_asserts
	import pmcal_pkg::*;
(
	input wire logic        aclk,
	input wire logic        aresetn,
	input wire logic        cmd_valid,
	input wire pmcal_cmd_e  cmd,
	input wire logic [7:0]  phase_delta,
	input wire logic        dc_mode,
	input wire logic        resp_valid,
	input wire logic        resp_ack,
	input wire logic        busy,
	input wire logic [15:0] gain_i,
	input wire logic [15:0] gain_v,
	input wire logic [15:0] gain_p,
	input wire logic [15:0] phase_comp,
	input wire logic [15:0] line_freq
);
	default clocking cb @(posedge aclk); endclocking
	default disable iff (!aresetn);
	logic acked;
	logic start;
	logic gains_ok;
	assign acked = resp_valid && resp_ack;
	assign start = cmd_valid && !busy;
	assign gains_ok = {1'b0, gain_i} >= GAIN_MIN && {1'b0, gain_v} >= GAIN_MIN
		&& {1'b0, gain_p} >= GAIN_MIN;
	gain_change_a: assert property (!$stable({gain_i, gain_v, gain_p}) |-> acked
		&& cmd == PMCAL_CMD_GAIN) else $error("gains moved without a gain ack");
	nak_keep_a: assert property (resp_valid && !resp_ack |->
		$stable({gain_i, gain_v, gain_p, phase_comp})) else $error("values moved on nak");
	ack_range_a: assert property (acked && cmd == PMCAL_CMD_GAIN |-> gains_ok)
		else $error("ack with a gain below the limit");
	gain_time_a: assert property (start && cmd == PMCAL_CMD_GAIN |-> ##[144:148]
		resp_valid) else $error("gain answer late or early");
	busy_hold_a: assert property (start && cmd == PMCAL_CMD_GAIN |=> busy [*8])
		else $error("busy dropped during gain calculation");
	phase_add_a: assert property (acked && cmd == PMCAL_CMD_PHASE |->
		phase_comp[7:0] == 8'($past(phase_comp[7:0]) + phase_delta))
		else $error("phase byte is not old plus delta");
	phase_lim_a: assert property (acked && cmd == PMCAL_CMD_PHASE |->
		{phase_comp[7], phase_comp[7:0]} == {$past(phase_comp[7]), $past(phase_comp[7:0])}
		+ {phase_delta[7], phase_delta}) else $error("phase correction overflowed");
	phase_time_a: assert property (start && cmd == PMCAL_CMD_PHASE |-> ##[1:2]
		resp_valid) else $error("phase answer missing");
	dc_freq_a: assert property (dc_mode && $past(dc_mode) |-> line_freq == 16'h0000)
		else $error("line frequency nonzero in dc mode");
	resp_pulse_a: assert property (resp_valid |=> !resp_valid)
		else $error("answer longer than one cycle");
endmodule // pmcal_asserts

// ### verif/test_power_monitor_calibration.sv
// test_power_monitor_calibration: AXI4-Lite bench for host and device ends.
// assumes both ends joined by pmcal_if and one 20 MHz clock.
`timescale 1ns/1ps
`define CHK(n, e, g) begin checked++; if ((g) !== (e)) begin miscompares++; \
	$display("BAD %s exp %h seen %h", n, e, g); end end
module test_power_monitor_calibration;
	import pmcal_pkg::*;
	logic        aclk, aresetn;
	logic [23:0] adc_i, adc_v, hpf_i, hpf_v, chan_i, chan_v;
	logic [31:0] raw_i, raw_v, raw_p, raw_q, out_i, out_v, out_p, out_q;
	logic [15:0] freq_meas;
	logic [7:0]  awaddr, araddr;
	logic [31:0] wdata, rdata, d;
	logic [3:0]  wstrb;
	logic [1:0]  bresp, rresp, r;
	logic        awvalid, awready, wvalid, wready, bvalid, bready;
	logic        arvalid, arready, rvalid, rready;
	int          miscompares, checked;
	logic [7:0]  pd [3] = '{8'h10, 8'h7f, 8'hf0};
	logic [15:0] pe [3] = '{16'h0010, 16'h0010, 16'h0000};
	logic        pa [3] = '{1'b1, 1'b0, 1'b1};
	pmcal_if lnk ();
	pmcal_dev u_pmcal_dev (.aclk(aclk), .aresetn(aresetn), .lnk(lnk), .adc_i(adc_i),
		.adc_v(adc_v), .hpf_i(hpf_i), .hpf_v(hpf_v), .raw_i(raw_i), .raw_v(raw_v),
		.raw_p(raw_p), .raw_q(raw_q), .freq_meas(freq_meas), .chan_i(chan_i),
		.chan_v(chan_v), .out_i(out_i), .out_v(out_v), .out_p(out_p), .out_q(out_q));
	pmcal_host u_pmcal_host (.aclk(aclk), .aresetn(aresetn), .lnk(lnk),
		.s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
		.s_axi_wdata(wdata), .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid),
		.s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid),
		.s_axi_bready(bready), .s_axi_araddr(araddr), .s_axi_arvalid(arvalid),
		.s_axi_arready(arready), .s_axi_rdata(rdata), .s_axi_rresp(rresp),
		.s_axi_rvalid(rvalid), .s_axi_rready(rready));
	pmcal_asserts u_pmcal_asserts (.aclk(aclk), .aresetn(aresetn),
		.cmd_valid(lnk.cmd_valid), .cmd(lnk.cmd), .phase_delta(lnk.phase_delta),
		.dc_mode(lnk.dc_mode), .resp_valid(lnk.resp_valid), .resp_ack(lnk.resp_ack),
		.busy(lnk.busy), .gain_i(lnk.gain_i), .gain_v(lnk.gain_v), .gain_p(lnk.gain_p),
		.phase_comp(lnk.phase_comp), .line_freq(lnk.line_freq));
	task automatic wr(input logic [7:0] a, input logic [31:0] v, output logic [1:0] rs);
		logic got;
		got = 1'b0;
		@(posedge aclk);
		awaddr <= a;
		wdata <= v;
		awvalid <= 1'b1;
		wvalid <= 1'b1;
		bready <= 1'b1;
		while (!got) begin
			@(posedge aclk);
			if (awready)
				awvalid <= 1'b0;
			if (wready)
				wvalid <= 1'b0;
			if (bvalid) begin
				rs = bresp;
				bready <= 1'b0;
				got = 1'b1;
			end
		end
	endtask
	task automatic rd(input logic [7:0] a, output logic [31:0] v, output logic [1:0] rs);
		logic got;
		got = 1'b0;
		@(posedge aclk);
		araddr <= a;
		arvalid <= 1'b1;
		rready <= 1'b1;
		while (!got) begin
			@(posedge aclk);
			if (arready)
				arvalid <= 1'b0;
			if (rvalid) begin
				v = rdata;
				rs = rresp;
				rready <= 1'b0;
				got = 1'b1;
			end
		end
	endtask
	task automatic rdchk(input logic [7:0] a, input logic [31:0] e, input string n);
		logic [31:0] v;
		logic [1:0]  s;
		rd(a, v, s);
		`CHK(n, e, v)
	endtask
	// issue a command, then poll status until the device is idle
	task automatic cmd_run(input logic [31:0] w, output logic [31:0] st);
		int n;
		logic [1:0] s;
		wr(A_CTRL, w, s);
		n = 0;
		st = 32'h1;
		while (st[0] && n < 400) begin
			rd(A_STATUS, st, s);
			n++;
		end
		`CHK("cmd_idle", 1'b0, st[0])
	endtask
	task automatic summarize();
		$display("checks %0d mismatches %0d", checked, miscompares);
		if (miscompares == 0 && checked > 0)
			$display("DONE - PASS");
		else
			$display("DONE - FAIL");
		$finish;
	endtask
	initial begin
		aclk = 1'b0;
		forever #25 aclk = ~aclk;
	end
	initial begin
		repeat (20000) @(posedge aclk);
		miscompares++;
		summarize();
	end
	initial begin
		aresetn = 1'b0;
		{awvalid, wvalid, bready, arvalid, rready} = 5'h00;
		{awaddr, araddr, wdata, wstrb} = {8'h00, 8'h00, 32'h0, 4'hf};
		{adc_i, adc_v, hpf_i, hpf_v} = {24'd1000, 24'd1100, 24'd2000, 24'd2200};
		{raw_i, raw_v, raw_p, raw_q} = {32'd250, 32'd250, 32'd250, 32'd100};
		freq_meas = 16'd60;
		repeat (12) @(posedge aclk);
		aresetn <= 1'b1;
		rdchk(A_GAINS_IV, 32'h80008000, "gains_iv");
		rdchk(A_GAIN_P, 32'h00008000, "gain_p");
		rdchk(A_RANGE, 32'h0000000c, "range");
		`CHK("out_i", 32'd2000, out_i)
		rd(8'h40, d, r);
		`CHK("unmapped", 2'h2, r)
		wr(A_CTRL, 32'h3, r);
		`CHK("save_early", 2'h2, r)
		$display("test reset done");
		wr(A_EXP_I, 32'd3000, r);
		wr(A_EXP_V, 32'd3000, r);
		wr(A_EXP_P, 32'd9000, r);
		cmd_run(32'h1, d);
		`CHK("nak_high", 1'b0, d[2])
		rdchk(A_GAINS_IV, 32'h80008000, "kept_iv");
		rdchk(A_GAIN_P, 32'h00008000, "kept_p");
		wr(A_EXP_P, 32'd3000, r);
		cmd_run(32'h1, d);
		`CHK("ack", 1'b1, d[2])
		rdchk(A_GAINS_IV, 32'hc000c000, "new_iv");
		rdchk(A_GAIN_P, 32'h0000c000, "new_p");
		`CHK("out_v", 32'd3000, out_v)
		wr(A_CTRL, 32'h3, r);
		`CHK("save_ok", 2'h0, r)
		$display("test gain done");
		wr(A_RANGE, 32'd13, r);
		repeat (2) @(posedge aclk);
		`CHK("out_i_r13", 32'd1500, out_i)
		wr(A_EXP_I, 32'd750, r);
		wr(A_EXP_V, 32'd1500, r);
		wr(A_EXP_P, 32'd1500, r);
		cmd_run(32'h1, d);
		`CHK("nak_low", 1'b0, d[2])
		rdchk(A_GAINS_IV, 32'hc000c000, "kept_low");
		$display("test range done");
		foreach (pd[k]) begin
			wr(A_PHASE, {24'h0, pd[k]}, r);
			cmd_run(32'h2, d);
			`CHK("phase_ack", pa[k], d[2])
			rdchk(A_PHASE, {16'h0, pe[k]}, "phase");
		end
		$display("test phase done");
		wr(A_OFFS, 32'h00050007, r);
		wr(A_FREQ, 32'h00030009, r);
		repeat (2) @(posedge aclk);
		`CHK("out_i_off", 32'd1507, out_i)
		`CHK("out_p_off", 32'd1505, out_p)
		`CHK("out_q_off", 32'd609, out_q)
		`CHK("chan_v_ac", 24'd2200, chan_v)
		`CHK("chan_i_ac", 24'd2000, chan_i)
		rdchk(A_FREQ, 32'd60, "freq");
		wr(A_CTRL, 32'h10, r);
		repeat (2) @(posedge aclk);
		`CHK("chan_i_dc", 24'd1003, chan_i)
		`CHK("chan_v_dc", 24'd1100, chan_v)
		rdchk(A_FREQ, 32'd0, "freq_dc");
		$display("test offsets done");
		summarize();
	end
endmodule // test_power_monitor_calibration
